//--- rtl/ras_pkg.sv
// Function
// - 31 words of 21 bits, 5-bit pointer
// - calls/interrupts push, returns pop program counter
// - program counter latches untouched by calls/returns
// - push increments pointer, then writes entry
// - pop reads entry, then decrements pointer
// - every reset clears pointer; zero is empty
// - only top entry visible, three byte registers
// - software reads and writes pointer 0..31
// - full flag after 31 pushes
// - overflow reset on: store pc+2, reset, zero
// - overflow reset off: pointer holds at 31
// - empty pop loads zero, sets underflow flag
// - overflow reset bit selects device reset
// - underflow zero load is no register reset
// - flags bits 7/6 clear-only, power-on cleared
// - pointer bits 4..0, bit 5 reads zero
// - push instruction stores pc, flow unchanged
// - pop instruction only decrements pointer
// - interrupt saves status, working, bank shadows
// - fast interrupt return restores shadows
// - fast call saves, fast return restores
// - one shadow level, later save overwrites
package ras_pkg;
   localparam int DEPTH = 31;
   localparam int PC_W = 21;
   localparam int PTR_W = 5;
   localparam logic [4:0] PTR_EMPTY = 5'h00;
   localparam logic [4:0] PTR_LAST = 5'h1e;
   localparam logic [4:0] PTR_FULL = 5'h1f;
   localparam logic [4:0] PTR_ONE = 5'h01;
   localparam logic [20:0] PC_STEP = 21'h0_0002;
   localparam logic [20:0] PC_ZERO = 21'h0_0000;
   // register byte addresses
   localparam logic [11:0] ADDR_POINTER = 12'h000;
   localparam logic [11:0] ADDR_TOP_LOW = 12'h004;
   localparam logic [11:0] ADDR_TOP_HIGH = 12'h008;
   localparam logic [11:0] ADDR_TOP_UPPER = 12'h00c;
   localparam logic [11:0] ADDR_CONFIG = 12'h010;
   // field positions
   localparam int FULL_BIT = 7;
   localparam int UNDER_BIT = 6;
   localparam int CFG_OVR_BIT = 0;
   localparam logic CFG_OVR_RESET = 1'b1;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
   // stack operations issued by the sequencer
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_CALL = 4'h1,
      OP_RELATIVE_CALL_INSTR = 4'h2,
      OP_INT_ACK = 4'h3,
      OP_PUSH_INSTR = 4'h4,
      OP_RETURN = 4'h5,
      OP_RETURN_WITH_LITERAL_INSTR = 4'h6,
      OP_RETURN_FROM_INTERRUPT_INSTR = 4'h7,
      OP_POP_INSTR = 4'h8
   } ras_op_type;
   typedef struct packed {
      ras_op_type op;
      logic fast;
      logic [20:0] pc;
      logic [7:0] status;
      logic [7:0] working_register;
      logic [7:0] bank_select_register;
   } ras_req_type;
   typedef struct packed {
      logic pc_valid;
      logic [20:0] pc;
      logic restore_valid;
      logic [7:0] status;
      logic [7:0] working_register;
      logic [7:0] bank_select_register;
   } ras_ans_type;
endpackage

//--- rtl/ras_stack.sv
module ras_stack (
   input wire logic pclk, // instruction clock
   input wire logic presetn, // power-on reset, active low
   input wire logic core_reset, // other device resets, sync
   input wire ras_pkg::ras_req_type core_req, // sequencer request
   output ras_pkg::ras_ans_type core_ans, // loads back to core
   output logic device_reset_req, // overflow/underflow reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr // apb error
);
   // stack storage, entry 0 has no word behind it
   logic [20:0] mem [1:ras_pkg::DEPTH];
   logic [4:0] ptr;
   logic full_flag;
   logic under_flag;
   logic ovr_en;
   logic [7:0] sh_status;
   logic [7:0] sh_working_register;
   logic [7:0] sh_bsr;
   logic reset_pend;
   logic [4:0] next_ptr;

   wire ras_pkg::ras_op_type op = core_req.op;
   wire is_push = (op == ras_pkg::OP_CALL) || (op == ras_pkg::OP_RELATIVE_CALL_INSTR)
      || (op == ras_pkg::OP_INT_ACK) || (op == ras_pkg::OP_PUSH_INSTR);
   wire is_ret = (op == ras_pkg::OP_RETURN) || (op == ras_pkg::OP_RETURN_WITH_LITERAL_INSTR)
      || (op == ras_pkg::OP_RETURN_FROM_INTERRUPT_INSTR);
   wire is_drop = (op == ras_pkg::OP_POP_INSTR);
   wire is_pop = is_ret || is_drop;
   wire core_op = (is_push || is_pop) && !core_reset;
   wire ptr_zero = (ptr == ras_pkg::PTR_EMPTY);
   wire ptr_last = (ptr == ras_pkg::PTR_LAST);
   wire ptr_full = (ptr == ras_pkg::PTR_FULL);

   // stack events
   wire full_event = core_op && is_push && (ptr_last || ptr_full);
   wire under_event = core_op && is_pop && ptr_zero;
   wire push_wr = core_op && is_push && !ptr_full;
   wire [4:0] push_idx = ptr + ras_pkg::PTR_ONE;
   wire [20:0] push_val = (ptr_last && ovr_en) ?
      core_req.pc + ras_pkg::PC_STEP : core_req.pc;
   wire [20:0] top_val = ptr_zero ? ras_pkg::PC_ZERO : mem[ptr];

   // shadow save and restore triggers
   wire save_shadow = !core_reset && ((op == ras_pkg::OP_INT_ACK)
      || ((op == ras_pkg::OP_CALL) && core_req.fast));
   wire do_restore = !core_reset && core_req.fast
      && ((op == ras_pkg::OP_RETURN_FROM_INTERRUPT_INSTR) || (op == ras_pkg::OP_RETURN));

   // apb phase and address decode
   wire setup = psel && !penable;
   wire wr_acc = psel && penable && pwrite;
   wire sel_ptr = (paddr == ras_pkg::ADDR_POINTER);
   wire sel_low = (paddr == ras_pkg::ADDR_TOP_LOW);
   wire sel_high = (paddr == ras_pkg::ADDR_TOP_HIGH);
   wire sel_upper = (paddr == ras_pkg::ADDR_TOP_UPPER);
   wire sel_cfg = (paddr == ras_pkg::ADDR_CONFIG);
   wire mapped = sel_ptr || sel_low || sel_high || sel_upper || sel_cfg;
   wire wr_ptr = wr_acc && sel_ptr;
   wire wr_cfg = wr_acc && sel_cfg;
   wire wr_tos = wr_acc && (sel_low || sel_high || sel_upper)
      && !ptr_zero && !core_op && !core_reset;
   wire clr_full = wr_ptr && !pwdata[ras_pkg::FULL_BIT];
   wire clr_under = wr_ptr && !pwdata[ras_pkg::UNDER_BIT];

   // top entry with one software byte replaced
   wire [20:0] tos_wdata = sel_low ? {top_val[20:8], pwdata[7:0]} :
      sel_high ? {top_val[20:16], pwdata[7:0], top_val[7:0]} :
      {pwdata[4:0], top_val[15:0]};

   // pointer register image, bit 5 zero
   wire [7:0] ptr_image = {full_flag, under_flag, 1'b0, ptr};
   wire [31:0] rd_mux = sel_ptr ? {24'h00_0000, ptr_image} :
      sel_low ? {24'h00_0000, top_val[7:0]} :
      sel_high ? {24'h00_0000, top_val[15:8]} :
      sel_upper ? {27'h000_0000, top_val[20:16]} :
      sel_cfg ? {31'h0000_0000, ovr_en} : ras_pkg::DATA_ZERO;

   always_comb
   begin
      next_ptr = ptr;
      if (core_reset)
         next_ptr = ras_pkg::PTR_EMPTY;
      else if (core_op && is_push)
         next_ptr = full_event ?
            (ovr_en ? ras_pkg::PTR_EMPTY : ras_pkg::PTR_FULL) : push_idx;
      else if (core_op && is_pop)
         next_ptr = ptr_zero ? ras_pkg::PTR_EMPTY : ptr - ras_pkg::PTR_ONE;
      else if (wr_ptr)
         next_ptr = pwdata[4:0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ptr <= ras_pkg::PTR_EMPTY;
      else
         ptr <= next_ptr;
   end

   always_ff @(posedge pclk)
   begin
      if (push_wr)
         mem[push_idx] <= push_val;
      else if (wr_tos)
         mem[ptr] <= tos_wdata;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         full_flag <= 1'b0;
         under_flag <= 1'b0;
      end
      else
      begin
         full_flag <= (full_flag && !clr_full) || full_event;
         under_flag <= (under_flag && !clr_under) || under_event;
      end
   end

   // overflow reset enable, power-on only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ovr_en <= ras_pkg::CFG_OVR_RESET;
      else if (wr_cfg)
         ovr_en <= pwdata[ras_pkg::CFG_OVR_BIT];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         reset_pend <= 1'b0;
         device_reset_req <= 1'b0;
      end
      else
      begin
         reset_pend <= (full_event || under_event) && ovr_en;
         device_reset_req <= reset_pend;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sh_status <= 8'h00;
         sh_working_register <= 8'h00;
         sh_bsr <= 8'h00;
      end
      else if (save_shadow)
      begin
         sh_status <= core_req.status;
         sh_working_register <= core_req.working_register;
         sh_bsr <= core_req.bank_select_register;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         core_ans.pc_valid <= 1'b0;
         core_ans.pc <= ras_pkg::PC_ZERO;
         core_ans.restore_valid <= 1'b0;
         core_ans.status <= 8'h00;
         core_ans.working_register <= 8'h00;
         core_ans.bank_select_register <= 8'h00;
      end
      else
      begin
         core_ans.pc_valid <= core_op && is_ret;
         if (core_op && is_ret)
            core_ans.pc <= top_val;
         core_ans.restore_valid <= do_restore;
         if (do_restore)
         begin
            core_ans.status <= sh_status;
            core_ans.working_register <= sh_working_register;
            core_ans.bank_select_register <= sh_bsr;
         end
      end
   end

   // apb read data and error, captured at setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= ras_pkg::DATA_ZERO;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         prdata <= pwrite ? ras_pkg::DATA_ZERO : rd_mux;
         pslverr <= !mapped;
      end
   end

   // every access answers in its first access cycle
   assign pready = penable;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire push_plain = core_op && is_push && !ptr_last && !ptr_full;
   wire pop_plain = core_op && is_pop && !ptr_zero;

   sequence s_full_commit;
      full_flag && (ptr == ras_pkg::PTR_EMPTY) && !device_reset_req;
   endsequence
   sequence s_reset_out;
      device_reset_req ##1 !device_reset_req;
   endsequence

   property p_push_inc;
      push_plain |=> (ptr == $past(ptr) + ras_pkg::PTR_ONE)
         && (top_val == $past(core_req.pc));
   endproperty
   a_push_inc: assert property (p_push_inc)
      else $error("push did not advance pointer and store pc");

   property p_pop_dec;
      pop_plain && is_ret |=> core_ans.pc_valid
         && (core_ans.pc == $past(top_val))
         && (ptr == $past(ptr) - ras_pkg::PTR_ONE);
   endproperty
   a_pop_dec: assert property (p_pop_dec)
      else $error("return did not load entry then decrement");

   property p_underflow;
      core_op && is_ret && ptr_zero |=> under_flag && core_ans.pc_valid
         && (core_ans.pc == ras_pkg::PC_ZERO) && ptr_zero;
   endproperty
   a_underflow: assert property (p_underflow)
      else $error("empty pop handled wrongly");

   property p_full_reset;
      push_wr && ptr_last && ovr_en |=> s_full_commit ##1 s_reset_out;
   endproperty
   a_full_reset: assert property (p_full_reset)
      else $error("overflow reset sequence wrong");

   property p_full_hold;
      core_op && is_push && ptr_full && !ovr_en |=>
         (ptr == ras_pkg::PTR_FULL) && full_flag && $stable(mem[31]);
   endproperty
   a_full_hold: assert property (p_full_hold)
      else $error("push past full changed stack");

   property p_core_reset;
      core_reset |=> ptr_zero && ($past(full_flag) == full_flag
         || $past(clr_full));
   endproperty
   a_core_reset: assert property (p_core_reset)
      else $error("device reset did not clear pointer only");

   property p_flag_sticky;
      under_flag && !clr_under |=> under_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("underflow flag lost without clear");

   property p_no_reset_off;
      (full_event || under_event) && !ovr_en |=> ##1 !device_reset_req;
   endproperty
   a_no_reset_off: assert property (p_no_reset_off)
      else $error("reset raised with overflow reset disabled");

   property p_shadow;
      (op == ras_pkg::OP_INT_ACK) && !core_reset |=>
         (sh_status == $past(core_req.status))
         && (sh_working_register == $past(core_req.working_register))
         && (sh_bsr == $past(core_req.bank_select_register));
   endproperty
   a_shadow: assert property (p_shadow)
      else $error("interrupt did not save shadows");

   property p_drop;
      pop_plain && is_drop |=> !core_ans.pc_valid
         && (ptr == $past(ptr) - ras_pkg::PTR_ONE);
   endproperty
   a_drop: assert property (p_drop)
      else $error("pop instruction misbehaved");

   // full flag on the 31st push
   property p_full_set;
      push_wr && ptr_last && !ovr_en |=> full_flag
         && (ptr == ras_pkg::PTR_FULL) && (top_val == $past(core_req.pc));
   endproperty
   a_full_set: assert property (p_full_set)
      else $error("31st push did not fill stack");

   property p_ptr_write;
      wr_ptr && !core_op && !core_reset |=> ptr == $past(pwdata[4:0]);
   endproperty
   a_ptr_write: assert property (p_ptr_write)
      else $error("pointer write not applied");

   property p_ptr_image;
      setup && sel_ptr && !pwrite |=> (prdata[4:0] == $past(ptr))
         && !prdata[5] && (prdata[7] == $past(full_flag));
   endproperty
   a_ptr_image: assert property (p_ptr_image)
      else $error("pointer image read wrongly");

   property p_flag_clear;
      clr_under && !under_event && clr_full && !full_event
         |=> !under_flag && !full_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag clear not applied");

   property p_tos_write;
      wr_tos && sel_low |=> top_val[7:0] == $past(pwdata[7:0]);
   endproperty
   a_tos_write: assert property (p_tos_write)
      else $error("top entry write not applied");

   property p_push_flow;
      core_op && is_push |=> !core_ans.pc_valid;
   endproperty
   a_push_flow: assert property (p_push_flow)
      else $error("push changed program flow");

   property p_restore;
      do_restore |=> core_ans.restore_valid
         && (core_ans.status == $past(sh_status))
         && (core_ans.working_register == $past(sh_working_register))
         && (core_ans.bank_select_register == $past(sh_bsr));
   endproperty
   a_restore: assert property (p_restore)
      else $error("fast return did not restore shadows");

   property p_no_restore;
      core_op && !do_restore |=> !core_ans.restore_valid;
   endproperty
   a_no_restore: assert property (p_no_restore)
      else $error("restore without fast return");

   property p_under_reset;
      under_event && ovr_en |=> under_flag ##1 s_reset_out;
   endproperty
   a_under_reset: assert property (p_under_reset)
      else $error("underflow reset sequence wrong");

   property p_sfr_keep;
      under_event && !wr_cfg |=> (ovr_en == $past(ovr_en))
         && (sh_working_register == $past(sh_working_register)) && (sh_status == $past(sh_status));
   endproperty
   a_sfr_keep: assert property (p_sfr_keep)
      else $error("underflow disturbed other registers");
endmodule

//--- bench/ras_seq_model.sv
module ras_seq_model (
   input wire logic pclk, // instruction clock
   output ras_pkg::ras_req_type core_req // request to stack
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle from time zero
   initial core_req = '0;
   // one op for one edge, then idle with scrambled fields
   task automatic issue(input ras_pkg::ras_req_type r);
      ras_pkg::ras_req_type idle;
      idle = ~r;
      idle.op = ras_pkg::OP_NONE;
      @(posedge pclk);
      core_req <= r;
      @(posedge pclk);
      core_req <= idle;
   endtask
endmodule

//--- bench/test_return_address_stack.sv
module test_return_address_stack;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn, core_reset, psel, penable, pwrite, pready, pslverr;
   logic device_reset_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   ras_pkg::ras_req_type core_req;
   ras_pkg::ras_ans_type core_ans;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;
   int seed, k, ptr;
   logic full, under, ovr;
   logic [20:0] stk [32];
   logic [23:0] sh;
   ras_seq_model i_seq (.pclk(pclk), .core_req(core_req));
   ras_stack i_dut (.pclk(pclk), .presetn(presetn), .core_reset(core_reset),
      .core_req(core_req), .core_ans(core_ans),
      .device_reset_req(device_reset_req), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   // 200 mhz clock
   always #2.5 pclk = ~pclk;
   task automatic results;
      if (n_mismatch == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   // expected register contents from the model
   function automatic logic [31:0] exp_rd(input logic [11:0] a);
      logic [20:0] t;
      t = (ptr == 0) ? 21'h0_0000 : stk[ptr];
      case (a)
         ras_pkg::ADDR_POINTER: exp_rd = 32'({full, under, 1'b0, ptr[4:0]});
         ras_pkg::ADDR_TOP_LOW: exp_rd = 32'(t[7:0]);
         ras_pkg::ADDR_TOP_HIGH: exp_rd = 32'(t[15:8]);
         ras_pkg::ADDR_TOP_UPPER: exp_rd = 32'(t[20:16]);
         ras_pkg::ADDR_CONFIG: exp_rd = 32'(ovr);
         default: exp_rd = 32'h0000_0000;
      endcase
   endfunction
   // one apb transfer, compared and applied to the model
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      logic err;
      err = (a > ras_pkg::ADDR_CONFIG) || (a[1:0] != 2'b00);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // wait for ready, the bench timeout bounds it
      while (pready !== 1'b1)
         @(posedge pclk);
      check(pslverr === err && (w || prdata === exp_rd(a)),
         "register access");
      psel <= 1'b0;
      penable <= 1'b0;
      if (w && !err)
         case (a)
            ras_pkg::ADDR_POINTER:
            begin
               ptr = d[4:0];
               full &= d[7];
               under &= d[6];
            end
            ras_pkg::ADDR_TOP_LOW: if (ptr != 0) stk[ptr][7:0] = d[7:0];
            ras_pkg::ADDR_TOP_HIGH: if (ptr != 0) stk[ptr][15:8] = d[7:0];
            ras_pkg::ADDR_TOP_UPPER: if (ptr != 0) stk[ptr][20:16] = d[4:0];
            ras_pkg::ADDR_CONFIG: ovr = d[0];
            default: ;
         endcase
   endtask
   task automatic regs;
      for (int i = 0; i < 5; i++)
         apb(12'(4 * i), 1'b0, 32'h0000_0000);
   endtask
   // one sequencer op, model update and answer checks
   task automatic op(input ras_pkg::ras_op_type o, input logic f);
      ras_pkg::ras_req_type r;
      logic [20:0] pc;
      logic v, rv, rst;
      r = {o, f, 21'($random(seed)), 24'($random(seed))};
      {v, rv, rst, pc} = '0;
      i_seq.issue(r);
      if (o inside {ras_pkg::OP_CALL, ras_pkg::OP_RELATIVE_CALL_INSTR,
            ras_pkg::OP_INT_ACK, ras_pkg::OP_PUSH_INSTR})
      begin
         if (o == ras_pkg::OP_INT_ACK || (o == ras_pkg::OP_CALL && f))
            sh = {r.status, r.working_register, r.bank_select_register};
         // the 31st push stores pc + 2 when overflow reset is on
         if (ptr == 30 && ovr)
            r.pc = r.pc + ras_pkg::PC_STEP;
         if (ptr != 31)
            stk[++ptr] = r.pc;
         if (ptr == 31)
         begin
            full = 1'b1;
            rst = ovr;
            if (ovr)
               ptr = 0;
         end
      end
      else if (o != ras_pkg::OP_NONE)
      begin
         v = (o != ras_pkg::OP_POP_INSTR);
         rv = f && (o == ras_pkg::OP_RETURN || o == ras_pkg::OP_RETURN_FROM_INTERRUPT_INSTR);
         if (ptr == 0)
            {under, rst} = {1'b1, ovr};
         else
            pc = stk[ptr--];
      end
      #1;
      check(core_ans.pc_valid === v && (!v || core_ans.pc === pc),
         "pc");
      check(core_ans.restore_valid === rv && (!rv ||
         {core_ans.status, core_ans.working_register, core_ans.bank_select_register} === sh), "shadow");
      @(posedge pclk);
      #1;
      check(device_reset_req === rst, "device reset");
      regs;
   endtask
   // bounded run
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_mismatch++;
         results;
      end
   end
   initial
   begin
      // seed 92809
      {seed, ptr, full, under, ovr, sh} =
         {32'h0001_6a89, 32'h0000_0000, 3'b001, 24'h00_0000};
      {presetn, core_reset, psel, penable, pwrite} = '0;
      {paddr, pwdata} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      regs;
      apb(12'h014, 1'b0, 32'h0000_0000);
      apb(12'h020, 1'b1, 32'hffff_ffff);
      apb(ras_pkg::ADDR_CONFIG, 1'b1, 32'h0000_0000);
      op(ras_pkg::OP_POP_INSTR, 1'b0);
      op(ras_pkg::OP_RETURN, 1'b0);
      apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h0000_00c0);
      apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h0000_0000);
      repeat (32) op(ras_pkg::OP_CALL, 1'b0);
      apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h0000_0005);
      for (int i = 1; i < 4; i++)
         apb(12'(4 * i), 1'b1, $random(seed));
      op(ras_pkg::OP_RETURN, 1'b0);
      op(ras_pkg::OP_INT_ACK, 1'b0);
      op(ras_pkg::OP_INT_ACK, 1'b0);
      op(ras_pkg::OP_RETURN_FROM_INTERRUPT_INSTR, 1'b1);
      op(ras_pkg::OP_CALL, 1'b1);
      op(ras_pkg::OP_RELATIVE_CALL_INSTR, 1'b0);
      op(ras_pkg::OP_RETURN_WITH_LITERAL_INSTR, 1'b0);
      op(ras_pkg::OP_RETURN, 1'b1);
      op(ras_pkg::OP_PUSH_INSTR, 1'b0);
      op(ras_pkg::OP_POP_INSTR, 1'b0);
      repeat (60)
      begin
         k = $unsigned($random(seed)) % 9;
         op(ras_pkg::ras_op_type'(k[3:0]), 1'($random(seed)));
      end
      apb(ras_pkg::ADDR_CONFIG, 1'b1, 32'h0000_0001);
      apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h0000_001e);
      op(ras_pkg::OP_CALL, 1'b0);
      apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h0000_009f);
      regs;
      apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h0000_0080);
      op(ras_pkg::OP_POP_INSTR, 1'b0);
      apb(ras_pkg::ADDR_POINTER, 1'b1, 32'h0000_00c3);
      @(posedge pclk);
      core_reset <= 1'b1;
      @(posedge pclk);
      core_reset <= 1'b0;
      ptr = 0;
      regs;
      // power-on reset in mid-run clears flags and sets config to overflow reset on
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      {ptr, full, under, ovr, sh} =
         {32'h0000_0000, 3'b001, 24'h00_0000};
      regs;
      results;
   end
endmodule
